// ==== shared/sar_adc_pkg.sv ====
// Package for the converter configuration and control block.
// Holds register offsets, field positions, reset values, timing and the APB carrier type.
// Assumes a single 25 MHz system clock shared by the bus and the block.
`default_nettype none
package sar_adc_pkg;
  // Bus widths.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte addresses, one aligned word each.
  localparam logic [ADDR_W-1:0] CFG_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h04;

  // Configuration register fields.
  localparam int CFG_DIV_LSB = 3;
  localparam int CFG_DIV_W = 5;
  localparam int CFG_RSV_BIT = 2;
  localparam int CFG_GAIN_LSB = 0;
  localparam logic [7:0] CFG_RESET = 8'hf8;

  // Control register fields.
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_TM_BIT = 6;
  localparam int CTRL_DONE_BIT = 5;
  localparam int CTRL_BUSY_BIT = 4;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_WIN_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Start-mode code that means a software write of one to the busy bit.
  localparam logic [2:0] MODE_SW_START = 3'h0;

  // Converter clocks spent tracking before a conversion in low-power track mode.
  localparam int TRACK_CLOCKS = 3;
  // Default number of converter clocks a conversion takes.
  localparam int CONV_CLOCKS_DEF = 8;

  // System clock and the ceiling advised for the converter clock.
  localparam int SYS_CLK_HZ = 25000000;
  localparam int CONV_CLK_MAX_HZ = 6000000;
  // Smallest divider field that keeps the converter clock under its ceiling.
  localparam int DIV_MIN = (SYS_CLK_HZ + CONV_CLK_MAX_HZ - 1) / CONV_CLK_MAX_HZ - 1;

  // Gain codes.
  localparam logic [1:0] GAIN_HALF = 2'h0;
  localparam logic [1:0] GAIN_ONE = 2'h1;
  localparam logic [1:0] GAIN_TWO = 2'h2;
  localparam logic [1:0] GAIN_FOUR = 2'h3;

  // APB request as driven by the master.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_t;

  // Configuration register layout.
  typedef struct packed {
    logic [4:0] clock_divider_field;
    logic rsv;
    logic [1:0] amplifier_gain_code;
  } cfg_reg_t;

  // Control register layout.
  typedef struct packed {
    logic converter_power_enable;
    logic track_mode_select;
    logic conversion_done_flag;
    logic conversion_busy;
    logic [2:0] start_mode_field;
    logic window_match_flag;
  } ctrl_reg_t;
endpackage
`default_nettype wire

// ==== rtl/sar_adc_config_control.sv ====
// Configuration and control logic of an 8-bit successive-approximation converter.
// Assumes an APB master on sys_clk_i and a hardware start strobe from logic on the same clock.
//
// Summary of operation
// - The converter clock period is the divider field plus one system clock periods.
// - Bit 2 of the configuration register reads as zero and ignores writes.
// - The two-bit gain code selects 0.5, 1, 2 or 4 for codes 00, 01, 10 and 11.
// - Track mode 0 tracks continuously except while converting; mode 1 tracks only in a window after each start.
// - Hardware sets the done flag at the end of a conversion; only a software zero clears it.
`default_nettype none
module sar_adc_config_control #(
  parameter int CONV_CLOCKS = sar_adc_pkg::CONV_CLOCKS_DEF
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire sar_adc_pkg::apb_req_t apb_req_i,
  input wire logic hw_start_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic converter_clock_o,
  output logic [1:0] amplifier_gain_code_o,
  output logic converter_power_o,
  output logic tracking_o,
  output logic converting_o
);

  // The step counter is five bits wide, so longer conversions cannot be counted.
  initial begin
    if (CONV_CLOCKS < 1 || CONV_CLOCKS > 31) begin
      $error("CONV_CLOCKS must lie between 1 and 31");
    end
  end

  localparam logic [4:0] TRACK_LAST = 5'(sar_adc_pkg::TRACK_CLOCKS - 1);
  localparam logic [4:0] CONV_LAST = 5'(CONV_CLOCKS - 1);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TRACK,
    ST_CONVERT
  } conv_state_t;

  sar_adc_pkg::cfg_reg_t cfg_q;
  sar_adc_pkg::ctrl_reg_t ctrl_q;
  conv_state_t state_q;
  logic [4:0] div_cnt_q;
  logic [4:0] step_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic conv_clk_q;
  logic tick;
  logic wr_en;
  logic rd_en;
  logic hit_cfg;
  logic hit_ctrl;
  logic sw_start;
  logic start;
  logic conv_end;
  logic abort;

  // True when an address equals the given register offset.
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] offset);
    addr_hit = (addr == offset);
  endfunction

  // The access phase gets one wait state so that every answer comes from a flip-flop.
  assign hit_cfg = addr_hit(apb_req_i.paddr, sar_adc_pkg::CFG_OFFSET);
  assign hit_ctrl = addr_hit(apb_req_i.paddr, sar_adc_pkg::CTRL_OFFSET);
  assign wr_en = apb_req_i.psel && apb_req_i.penable && pready_q && apb_req_i.pwrite;
  assign rd_en = apb_req_i.psel && apb_req_i.penable && !pready_q && !apb_req_i.pwrite;

  // Ready rises in the second access cycle and drops right after the completing edge.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (apb_req_i.psel && apb_req_i.penable && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= !(hit_cfg || hit_ctrl);
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Read data is captured with ready; unmapped addresses read as zero.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_en) begin
      if (hit_cfg) begin
        prdata_q <= {24'h00_0000, cfg_q.clock_divider_field, 1'b0,
                     cfg_q.amplifier_gain_code};
      end else if (hit_ctrl) begin
        prdata_q <= {24'h00_0000, ctrl_q};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end else if (pready_q) begin
      prdata_q <= 32'h0000_0000;
    end
  end

  // Configuration register; the unused bit is never stored.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cfg_q <= sar_adc_pkg::CFG_RESET;
      cfg_q.rsv <= 1'b0;
    end else if (wr_en && hit_cfg) begin
      cfg_q.clock_divider_field <=
        apb_req_i.pwdata[sar_adc_pkg::CFG_DIV_LSB +: sar_adc_pkg::CFG_DIV_W];
      cfg_q.amplifier_gain_code <= apb_req_i.pwdata[sar_adc_pkg::CFG_GAIN_LSB +: 2];
      cfg_q.rsv <= 1'b0;
    end
  end

  // Converter clock divider: a tick every divider plus one system clocks.
  // A divider of zero gives a tick every cycle and a clock output held high.
  assign tick = (div_cnt_q == cfg_q.clock_divider_field);

  // A configuration write restarts the count, so a smaller divider never leaves the
  // counter above its end point, where it would have to wrap before the next tick.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      div_cnt_q <= 5'h00;
    end else if (tick || !ctrl_q.converter_power_enable || (wr_en && hit_cfg)) begin
      div_cnt_q <= 5'h00;
    end else begin
      div_cnt_q <= div_cnt_q + 5'h01;
    end
  end

  // The clock output is high for the first half of each period and stops when powered down.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      conv_clk_q <= 1'b0;
    end else if (!ctrl_q.converter_power_enable) begin
      conv_clk_q <= 1'b0;
    end else if (tick) begin
      conv_clk_q <= 1'b1;
    end else begin
      conv_clk_q <= ((div_cnt_q + 5'h01) <= (cfg_q.clock_divider_field >> 1));
    end
  end

  // Start sources: a software write of one to busy in mode zero, the strobe otherwise.
  // A start written together with a cleared enable bit would be aborted at once, so it is ignored.
  assign sw_start = wr_en && hit_ctrl && apb_req_i.pwdata[sar_adc_pkg::CTRL_BUSY_BIT] &&
                    apb_req_i.pwdata[sar_adc_pkg::CTRL_EN_BIT];
  assign start = ctrl_q.converter_power_enable && (state_q == ST_IDLE) &&
                 ((ctrl_q.start_mode_field == sar_adc_pkg::MODE_SW_START) ? sw_start
                                                                          : hw_start_i);
  assign conv_end = (state_q == ST_CONVERT) && tick && (step_q == CONV_LAST) && !abort;
  assign abort = !ctrl_q.converter_power_enable;

  // Conversion sequencer; low-power track mode inserts a tracking window first.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      step_q <= 5'h00;
    end else if (abort) begin
      state_q <= ST_IDLE;
      step_q <= 5'h00;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ctrl_q.track_mode_select ? ST_TRACK : ST_CONVERT;
            step_q <= 5'h00;
          end
        end
        ST_TRACK: begin
          if (tick) begin
            if (step_q == TRACK_LAST) begin
              state_q <= ST_CONVERT;
              step_q <= 5'h00;
            end else begin
              step_q <= step_q + 5'h01;
            end
          end
        end
        ST_CONVERT: begin
          if (tick) begin
            if (conv_end) begin
              state_q <= ST_IDLE;
              step_q <= 5'h00;
            end else begin
              step_q <= step_q + 5'h01;
            end
          end
        end
      endcase
    end
  end

  // Control register. Busy mirrors the sequencer; done is set as busy falls and a
  // completion in the same cycle as a clearing write wins over the clear.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ctrl_q <= sar_adc_pkg::CTRL_RESET;
    end else begin
      if (wr_en && hit_ctrl) begin
        ctrl_q.converter_power_enable <= apb_req_i.pwdata[sar_adc_pkg::CTRL_EN_BIT];
        ctrl_q.track_mode_select <= apb_req_i.pwdata[sar_adc_pkg::CTRL_TM_BIT];
        ctrl_q.start_mode_field <= apb_req_i.pwdata[sar_adc_pkg::CTRL_MODE_LSB +: 3];
        ctrl_q.window_match_flag <= apb_req_i.pwdata[sar_adc_pkg::CTRL_WIN_BIT];
      end
      if (conv_end) begin
        ctrl_q.conversion_done_flag <= 1'b1;
      end else if (wr_en && hit_ctrl && !apb_req_i.pwdata[sar_adc_pkg::CTRL_DONE_BIT]) begin
        ctrl_q.conversion_done_flag <= 1'b0;
      end
      ctrl_q.conversion_busy <= start || ((state_q != ST_IDLE) && !conv_end && !abort);
    end
  end

  // Analog-facing outputs, each from its own flip-flop.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      amplifier_gain_code_o <= sar_adc_pkg::GAIN_HALF;
      converter_power_o <= 1'b0;
      tracking_o <= 1'b0;
      converting_o <= 1'b0;
    end else begin
      amplifier_gain_code_o <= cfg_q.amplifier_gain_code;
      converter_power_o <= ctrl_q.converter_power_enable;
      converting_o <= !abort && (state_q == ST_CONVERT);
      if (!ctrl_q.converter_power_enable) begin
        tracking_o <= 1'b0;
      end else if (!ctrl_q.track_mode_select) begin
        tracking_o <= (state_q != ST_CONVERT);
      end else begin
        tracking_o <= (state_q == ST_TRACK);
      end
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign converter_clock_o = conv_clk_q;

  // Helper: cycles since the last tick, to check the divider period.
  logic [5:0] gap_q;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || tick || abort || (wr_en && hit_cfg)) begin
      gap_q <= 6'h00;
    end else begin
      gap_q <= gap_q + 6'h01;
    end
  end

  sequence s_clear_write;
    wr_en && hit_ctrl && !apb_req_i.pwdata[sar_adc_pkg::CTRL_DONE_BIT];
  endsequence

  sequence s_finish;
    conv_end;
  endsequence

  a_divider_period: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    tick |-> gap_q == {1'b0, cfg_q.clock_divider_field})
    else $error("Converter clock tick off its divider period.");

  a_unused_bit_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (rd_en && hit_cfg) |=> prdata_q[sar_adc_pkg::CFG_RSV_BIT] == 1'b0)
    else $error("Unused configuration bit read back as one.");

  a_gain_follows: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_en && hit_cfg) |=> ##1 amplifier_gain_code_o == $past(apb_req_i.pwdata[1:0], 2))
    else $error("Gain output does not follow the written code.");

  a_power_down_quiet: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !ctrl_q.converter_power_enable |=> !tracking_o && !converting_o && !conv_clk_q)
    else $error("Converter active while powered down.");

  a_track_mode_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ctrl_q.converter_power_enable && !ctrl_q.track_mode_select && state_q == ST_IDLE)
      |=> tracking_o)
    else $error("No continuous tracking in normal track mode.");

  a_low_power_track: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (start && ctrl_q.track_mode_select) |=> state_q == ST_TRACK ##1 tracking_o)
    else $error("Low-power track mode skipped its tracking window.");

  a_done_sets: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    s_finish |=> ctrl_q.conversion_done_flag && !ctrl_q.conversion_busy)
    else $error("Done flag not set when busy fell.");

  a_done_sticky: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ctrl_q.conversion_done_flag &&
      !(wr_en && hit_ctrl && !apb_req_i.pwdata[sar_adc_pkg::CTRL_DONE_BIT]))
      |=> ctrl_q.conversion_done_flag)
    else $error("Done flag cleared without a software write.");

  a_done_clears: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    s_clear_write |=> !ctrl_q.conversion_done_flag || $past(conv_end))
    else $error("Done flag survived a clearing write.");

  a_busy_fall_done: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $fell(ctrl_q.conversion_busy) && !$past(abort) |-> $rose(ctrl_q.conversion_done_flag)
      || $past(ctrl_q.conversion_done_flag))
    else $error("Busy fell without a completed conversion.");

  a_busy_on_start: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    start |=> ctrl_q.conversion_busy [*2])
    else $error("Busy not shown after a start.");

endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking testbench for the converter configuration and control block.
// Assumes the block answers APB on sys_clk_i and has no model on its far side.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CONV_N = 8;
  localparam int LIMIT = 20000;
  logic sys_clk;
  logic rst_n;
  sar_adc_pkg::apb_req_t req;
  logic hw_start;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic conv_clk;
  logic [1:0] gain;
  logic power;
  logic tracking;
  logic converting;
  logic [31:0] rd;
  logic er;
  int err_count;
  int compares;
  int cycles;

  sar_adc_config_control #(.CONV_CLOCKS(CONV_N)) i_dut (
    .sys_clk_i(sys_clk),
    .rst_n_i(rst_n),
    .apb_req_i(req),
    .hw_start_i(hw_start),
    .prdata_o(prdata),
    .pready_o(pready),
    .pslverr_o(pslverr),
    .converter_clock_o(conv_clk),
    .amplifier_gain_code_o(gain),
    .converter_power_o(power),
    .tracking_o(tracking),
    .converting_o(converting)
  );

  // Free-running 25 MHz system clock.
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // A hung handshake must still end the run with a verdict.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_count++;
      report_and_stop();
    end
  end

  // Prints the verdict and ends the simulation.
  task automatic report_and_stop();
    if (err_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Compares one value and counts the outcome.
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; an idle edge first keeps psel from being assigned twice in one step.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= addr;
    req.pwdata <= {24'h0, data};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees ready.
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // Counts system clocks between two rising edges of the converter clock.
  task automatic period(output int p);
    int n;
    p = 0;
    n = 0;
    while (conv_clk !== 1'b0 && n < 200) begin @(posedge sys_clk); n++; end
    while (conv_clk !== 1'b1 && n < 200) begin @(posedge sys_clk); n++; end
    while (conv_clk !== 1'b0 && n < 200) begin @(posedge sys_clk); n++; p++; end
    while (conv_clk !== 1'b1 && n < 200) begin @(posedge sys_clk); n++; p++; end
  endtask

  // Polls the control register until the busy bit drops, bounded.
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, sar_adc_pkg::CTRL_OFFSET, 8'h00);
      n++;
    end while (rd[4] !== 1'b0 && n < 40);
  endtask

  // Reset value of the power output and both registers.
  task automatic t_reset();
    chk("power", 1'b0, power);
    apb(1'b0, sar_adc_pkg::CFG_OFFSET, 8'h00);
    chk("cfg reset", 32'hf8, rd);
    apb(1'b0, sar_adc_pkg::CTRL_OFFSET, 8'h00);
    chk("ctrl reset", 32'h00, rd);
  endtask

  // Reserved bit stays zero and every gain code reaches the output.
  task automatic t_config();
    apb(1'b1, sar_adc_pkg::CFG_OFFSET, 8'hff);
    apb(1'b0, sar_adc_pkg::CFG_OFFSET, 8'h00);
    chk("cfg bit2", 32'hfb, rd);
    for (int g = 0; g < 4; g++) begin
      apb(1'b1, sar_adc_pkg::CFG_OFFSET, {5'h1f, 1'b1, g[1:0]});
      repeat (2) @(posedge sys_clk);
      chk("gain out", {30'h0, g[1:0]}, {30'h0, gain});
      apb(1'b0, sar_adc_pkg::CFG_OFFSET, 8'h00);
      chk("gain read", {24'h0, 5'h1f, 1'b0, g[1:0]}, rd);
    end
  endtask

  // An unmapped address is refused on write and read, and reads as zero.
  task automatic t_unmapped();
    apb(1'b1, 8'h08, 8'h55);
    chk("wr err", 1'b1, er);
    apb(1'b0, 8'h08, 8'h00);
    chk("rd err", 1'b1, er);
    chk("rd data", 32'h0, rd);
  endtask

  // Powering up, then the divided clock period for two divider values.
  task automatic t_divider();
    int p;
    apb(1'b1, sar_adc_pkg::CTRL_OFFSET, 8'h80);
    repeat (3) @(posedge sys_clk);
    chk("power on", 1'b1, power);
    chk("tracking idle", 1'b1, tracking);
    for (int d = sar_adc_pkg::DIV_MIN; d <= sar_adc_pkg::DIV_MIN + 3; d += 3) begin
      apb(1'b1, sar_adc_pkg::CFG_OFFSET, {d[4:0], 3'h0});
      period(p);
      period(p);
      chk("clk period", d + 1, p);
    end
  endtask

  // Software start in continuous tracking; the flag stays until written zero.
  task automatic t_convert();
    apb(1'b1, sar_adc_pkg::CFG_OFFSET, 8'h21);
    apb(1'b1, sar_adc_pkg::CTRL_OFFSET, 8'h90);
    repeat (3) @(posedge sys_clk);
    chk("converting", 1'b1, converting);
    chk("no tracking", 1'b0, tracking);
    apb(1'b0, sar_adc_pkg::CTRL_OFFSET, 8'h00);
    chk("busy", 32'h90, rd);
    wait_idle();
    chk("done at idle", 32'ha0, rd);
    repeat (40) @(posedge sys_clk);
    apb(1'b0, sar_adc_pkg::CTRL_OFFSET, 8'h00);
    chk("done sticky", 32'ha0, rd);
    chk("tracking back", 1'b1, tracking);
    apb(1'b1, sar_adc_pkg::CTRL_OFFSET, 8'ha0);
    apb(1'b0, sar_adc_pkg::CTRL_OFFSET, 8'h00);
    chk("done kept", 32'ha0, rd);
    apb(1'b1, sar_adc_pkg::CTRL_OFFSET, 8'h80);
    apb(1'b0, sar_adc_pkg::CTRL_OFFSET, 8'h00);
    chk("done clear", 32'h80, rd);
  endtask

  // Hardware start in low-power mode: tracking first, then conversion.
  task automatic t_low_power();
    int n;
    apb(1'b1, sar_adc_pkg::CTRL_OFFSET, 8'hc2);
    @(posedge sys_clk);
    hw_start <= 1'b1;
    @(posedge sys_clk);
    hw_start <= 1'b0;
    n = 0;
    while (tracking !== 1'b1 && n < 60) begin @(posedge sys_clk); n++; end
    chk("track first", 1'b0, converting);
    while (converting !== 1'b1 && n < 200) begin @(posedge sys_clk); n++; end
    chk("then convert", 1'b0, tracking);
    wait_idle();
    chk("hw done", 32'he2, rd);
  endtask

  // Shutdown removes power and stops the converter clock.
  task automatic t_power_off();
    int hi;
    hi = 0;
    apb(1'b1, sar_adc_pkg::CTRL_OFFSET, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk("power off", 1'b0, power);
    repeat (20) begin
      @(posedge sys_clk);
      if (conv_clk !== 1'b0) hi++;
    end
    chk("clk stopped", 0, hi);
  endtask

  // Main sequence.
  initial begin
    req = '0;
    hw_start = 1'b0;
    rst_n = 1'b0;
    err_count = 0;
    compares = 0;
    cycles = 0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_config();
    t_unmapped();
    t_divider();
    t_convert();
    t_low_power();
    t_power_off();
    report_and_stop();
  end
endmodule
`default_nettype wire
